// ### hw/link_activity_statistics.sv
// Link activity statistics with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "link_stats_params.svh"

module link_activity_statistics #(
  parameter int TICK_CYCLES = `LS_TICK_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire link_stats_pkg::link_events_t link0_ev,
  input  wire link_stats_pkg::link_events_t link1_ev,
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import link_stats_pkg::*;

  // The tick divider is 24 bits wide and needs at least two states.
  localparam int TICK_MIN = 2;
  localparam int TICK_MAX = 16777215;

  if (TICK_CYCLES < TICK_MIN) begin : g_tick_too_small
    $error("TICK_CYCLES below the divider minimum");
  end
  if (TICK_CYCLES > TICK_MAX) begin : g_tick_too_large
    $error("TICK_CYCLES exceeds the divider width");
  end

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  // Every register of the block lives in this one record.
  typedef struct packed {
    logic [23:0]   tick_cnt;
    logic          tick;
    link_events_t  ev0_s1;
    link_events_t  ev0_s2;
    link_events_t  ev1_s1;
    link_events_t  ev1_s2;
    dir_stats_t    a_rx;
    dir_stats_t    a_tx;
    dir_stats_t    b_rx;
    dir_stats_t    b_tx;
    logic          select;
    logic          aw_got;
    logic [11:0]   aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    rd_state_t     rd_state;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } state_t;

  // Present and next state of the whole block.
  state_t state_reg;
  state_t state_next;

  // Address classes of the register map.
  localparam logic [1:0] CLS_STATS = 2'b00;
  localparam logic [1:0] CLS_WORK  = 2'b01;
  localparam logic [1:0] CLS_SEL   = 2'b10;
  localparam logic [1:0] CLS_NONE  = 2'b11;

  // Sorts a word address into statistics, working, select or unmapped.
  function automatic logic [1:0] addr_class(input logic [11:0] addr);
    logic [1:0] c;
    if (addr < `LS_OFS_WORK_BASE) begin
      c = CLS_STATS;
    end else if (addr < `LS_OFS_SELECT) begin
      c = CLS_WORK;
    end else if (addr == `LS_OFS_SELECT) begin
      c = CLS_SEL;
    end else begin
      c = CLS_NONE;
    end
    return c;
  endfunction : addr_class

  // Adds one to a 16-bit value and wraps past the top.
  function automatic logic [15:0] bump16(input logic [15:0] v);
    return v + 16'h0001;
  endfunction : bump16

  // Returns the smaller of a stored extreme and a fresh interval.
  function automatic logic [15:0] keep_min(input logic [15:0] cur,
                                           input logic [15:0] cand);
    logic [15:0] r;
    r = cur;
    if (cand < cur) begin
      r = cand;
    end
    return r;
  endfunction : keep_min

  // Returns the larger of a stored extreme and a fresh interval.
  function automatic logic [15:0] keep_max(input logic [15:0] cur,
                                           input logic [15:0] cand);
    logic [15:0] r;
    r = cur;
    if (cand > cur) begin
      r = cand;
    end
    return r;
  endfunction : keep_max

  // Picks the physical link that feeds a statistics set.
  function automatic link_events_t route_ev(input logic sel,
                                            input link_events_t ev0,
                                            input link_events_t ev1,
                                            input logic second);
    link_events_t e;
    if (sel ^ second) begin
      e = ev1;
    end else begin
      e = ev0;
    end
    return e;
  endfunction : route_ev

  // Updates one direction: count, interval latch, extremes and running timer.
  function automatic dir_stats_t dir_update(input dir_stats_t d,
                                            input logic op,
                                            input logic tick);
    dir_stats_t r;
    logic [15:0] run;
    r = d;
    run = tick ? bump16(d.work) : d.work;
    if (op) begin
      r.count = bump16(d.count);
      if (d.seen) begin
        r.now = run;
        r.min = keep_min(d.min, run);
        r.max = keep_max(d.max, run);
      end
      r.seen = 1'b1;
      r.work = `LS_ZERO16;
    end else begin
      r.work = run;
    end
    return r;
  endfunction : dir_update

  // Returns the register word at a word index, or flags it unmapped.
  function automatic logic [32:0] reg_word(input state_t s,
                                           input logic [11:0] addr);
    logic [32:0] w;
    w = {1'b0, 32'h0000_0000};
    if (addr_class(addr) == CLS_STATS) begin
      case (addr[5:2])
        4'h0: w[15:0] = s.a_rx.count;
        4'h1: w[15:0] = s.a_rx.now;
        4'h2: w[15:0] = s.a_rx.min;
        4'h3: w[15:0] = s.a_rx.max;
        4'h4: w[15:0] = s.a_tx.count;
        4'h5: w[15:0] = s.a_tx.now;
        4'h6: w[15:0] = s.a_tx.min;
        4'h7: w[15:0] = s.a_tx.max;
        4'h8: w[15:0] = s.b_rx.count;
        4'h9: w[15:0] = s.b_rx.now;
        4'ha: w[15:0] = s.b_rx.min;
        4'hb: w[15:0] = s.b_rx.max;
        4'hc: w[15:0] = s.b_tx.count;
        4'hd: w[15:0] = s.b_tx.now;
        4'he: w[15:0] = s.b_tx.min;
        default: w[15:0] = s.b_tx.max;
      endcase
    end else if (addr_class(addr) == CLS_WORK) begin
      case (addr[3:2])
        2'h0: w[15:0] = s.a_rx.work;
        2'h1: w[15:0] = s.a_tx.work;
        2'h2: w[15:0] = s.b_rx.work;
        default: w[15:0] = s.b_tx.work;
      endcase
    end else if (addr_class(addr) == CLS_SEL) begin
      w[0] = s.select;
    end else begin
      w[32] = 1'b1;
    end
    return w;
  endfunction : reg_word

  // Values that a statistics set holds after reset.
  function automatic dir_stats_t dir_reset();
    dir_stats_t r;
    r.count = `LS_ZERO16;
    r.now   = `LS_ZERO16;
    r.min   = `LS_MIN_RESET;
    r.max   = `LS_ZERO16;
    r.work  = `LS_ZERO16;
    r.seen  = 1'b0;
    return r;
  endfunction : dir_reset

  // Helpers computed on every pass of the update process.
  link_events_t first_ev;
  link_events_t second_ev;
  logic         ev_a_rx;
  logic         ev_a_tx;
  logic         ev_b_rx;
  logic         ev_b_tx;
  logic         wr_open;
  logic [1:0]   wr_cls;
  logic [32:0]  rd_word;
  logic [11:0]  wr_addr;
  logic [11:0]  rd_addr;

  always_comb begin
    state_next = state_reg;
    first_ev  = route_ev(state_reg.select, state_reg.ev0_s2,
                         state_reg.ev1_s2, 1'b0);
    second_ev = route_ev(state_reg.select, state_reg.ev0_s2,
                         state_reg.ev1_s2, 1'b1);
    ev_a_rx = first_ev.rx_done;
    ev_a_tx = first_ev.tx_done;
    ev_b_rx = second_ev.rx_done;
    ev_b_tx = second_ev.tx_done;
    wr_open = !state_reg.bvalid && !srst;
    wr_addr = state_reg.aw_addr & 12'hffc;
    rd_addr = s_axi_araddr & 12'hffc;
    wr_cls  = addr_class(wr_addr);
    rd_word = reg_word(state_reg, rd_addr);

    // Two-stage synchronisers for the asynchronous link events.
    state_next.ev0_s1 = link0_ev;
    state_next.ev0_s2 = state_reg.ev0_s1;
    state_next.ev1_s1 = link1_ev;
    state_next.ev1_s2 = state_reg.ev1_s1;

    // Free-running divider that makes the 2.5 ms tick.
    if (state_reg.tick_cnt == TICK_LAST) begin
      state_next.tick_cnt = 24'h000000;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 24'h000001;
      state_next.tick = 1'b0;
    end

    // Statistics of each set and direction.
    state_next.a_rx = dir_update(state_reg.a_rx, ev_a_rx,
                                 state_reg.tick);
    state_next.a_tx = dir_update(state_reg.a_tx, ev_a_tx,
                                 state_reg.tick);
    state_next.b_rx = dir_update(state_reg.b_rx, ev_b_rx,
                                 state_reg.tick);
    state_next.b_tx = dir_update(state_reg.b_tx, ev_b_tx,
                                 state_reg.tick);

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && !state_reg.aw_got && wr_open) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_got && wr_open) begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      if (wr_cls == CLS_SEL) begin
        state_next.bresp = `LS_RESP_OKAY;
        if (state_reg.w_strb[0]) begin
          state_next.select = state_reg.w_data[0];
        end
      end else if (wr_cls != CLS_NONE) begin
        // Writes to statistics and working words change nothing.
        state_next.bresp = `LS_RESP_OKAY;
      end else begin
        state_next.bresp = `LS_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Read channel: one answer, then one idle cycle.
    unique case (state_reg.rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          state_next.rdata = rd_word[31:0];
          if (rd_word[32]) begin
            state_next.rresp = `LS_RESP_SLVERR;
          end else begin
            state_next.rresp = `LS_RESP_OKAY;
          end
          state_next.rd_state = RD_RESP;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          state_next.rd_state = RD_HOLD;
        end
      end
      RD_HOLD: begin
        state_next.rd_state = RD_IDLE;
      end
      default: begin
        state_next.rd_state = RD_IDLE;
      end
    endcase

    // Synchronous reset overrides every update above.
    if (srst) begin
      state_next.tick_cnt = 24'h000000;
      state_next.tick     = 1'b0;
      state_next.ev0_s1   = '0;
      state_next.ev0_s2   = '0;
      state_next.ev1_s1   = '0;
      state_next.ev1_s2   = '0;
      state_next.select   = 1'b0;
      state_next.aw_got   = 1'b0;
      state_next.aw_addr  = 12'h000;
      state_next.w_got    = 1'b0;
      state_next.w_data   = 32'h0000_0000;
      state_next.w_strb   = 4'h0;
      state_next.bvalid   = 1'b0;
      state_next.rdata    = 32'h0000_0000;
      state_next.a_rx = dir_reset();
      state_next.a_tx = dir_reset();
      state_next.b_rx = dir_reset();
      state_next.b_tx = dir_reset();
      state_next.bresp = `LS_RESP_OKAY;
      state_next.rresp = `LS_RESP_OKAY;
      state_next.rd_state = RD_IDLE;
    end
  end

  // One register stage holds all state.
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // Write address and data ready are refused while a write response still waits.
  assign s_axi_awready = !state_reg.aw_got && wr_open;
  assign s_axi_wready  = !state_reg.w_got && wr_open;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = (state_reg.rd_state == RD_IDLE) && !srst;
  assign s_axi_rvalid  = state_reg.rd_state == RD_RESP;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

endmodule : link_activity_statistics

// ### hw/link_stats_params.svh
// Register offsets, reset values and timing counts of the link statistics.
`ifndef LINK_STATS_PARAMS_SVH
`define LINK_STATS_PARAMS_SVH

`define LS_CLK_HZ          40000000
`define LS_TICK_US         2500
`define LS_TICK_CYCLES     ((`LS_CLK_HZ / 1000000) * `LS_TICK_US)

`define LS_OFS_STATS_BASE  12'h000
`define LS_OFS_WORK_BASE   12'h040
`define LS_OFS_SELECT      12'h050
`define LS_OFS_LAST        12'h050

`define LS_MIN_RESET       16'hffff
`define LS_ZERO16          16'h0000

`define LS_RESP_OKAY       2'b00
`define LS_RESP_SLVERR     2'b10

`endif

// ### hw/link_stats_pkg.sv
// Types shared by the link statistics block.
package link_stats_pkg;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] now;
    logic [15:0] min;
    logic [15:0] max;
    logic [15:0] work;
    logic        seen;
  } dir_stats_t;

  typedef struct packed {
    logic        rx_done;
    logic        tx_done;
  } link_events_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_RESP = 3'b010,
    RD_HOLD = 3'b100
  } rd_state_t;

endpackage : link_stats_pkg

// ### verif/link_station_model.sv
// Behavioural link station that reports completed operations.
`timescale 1ns/100ps
module link_station_model (
  input  wire logic                    sys_clk,
  output link_stats_pkg::link_events_t ev
);
  import link_stats_pkg::*;
  initial ev = '0;
  task automatic pulse(input logic rx);
    ev.rx_done <= rx;
    ev.tx_done <= !rx;
    @(posedge sys_clk);
    ev <= '0;
  endtask : pulse
endmodule : link_station_model

// ### verif/link_stats_checker.sv
// Bus timing checks of the link statistics register slave.
`timescale 1ns/100ps
module link_stats_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("address taken twice");
  AST_B_TIME: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RO_OKAY: assert property (wr_both ##0 (s_axi_awaddr <= 12'h04c)
    |-> ##2 s_axi_bresp == 2'b00) else $error("read-only write refused");
  AST_W_ERR: assert property (wr_both ##0 (s_axi_awaddr > 12'h050)
    |-> ##2 s_axi_bresp == 2'b10) else $error("unmapped write accepted");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready) else $error("write response stuck");
  AST_R_TIME: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_IDLE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && !s_axi_arready ##1 s_axi_arready) else $error("idle");
  AST_R_ERR: assert property (rd_take ##0 (s_axi_araddr > 12'h050) |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad read");
endmodule : link_stats_checker

bind link_activity_statistics link_stats_checker link_stats_checker_inst (
  .sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### verif/tb.sv
// Self-checking bench of the link statistics block.
`timescale 1ns/100ps
module tb;
  import link_stats_pkg::*;
  localparam int TICKS = 10;
  logic         sys_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic         s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  link_events_t link0_ev, link1_ev;
  int           n_errors = 0, n_tests = 0, cyc = 0, tgt, tnow = 0, sel = 0;
  int           cnt[4], nw[4], mn[4], mx[4], lt[4], arm[4];
  link_activity_statistics #(.TICK_CYCLES(TICKS))
    link_activity_statistics_inst (.*);
  link_station_model link0_inst (.sys_clk, .ev(link0_ev));
  link_station_model link1_inst (.sys_clk, .ev(link1_ev));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd
  task automatic op(input int lk, input int dir, input int k);
    int i;
    tgt += k * TICKS;
    tnow += k;
    while (cyc < tgt) @(posedge sys_clk);
    i = (lk ^ sel) * 2 + dir;
    if (lk == 0) link0_inst.pulse(dir == 0);
    else link1_inst.pulse(dir == 0);
    cnt[i] = (cnt[i] + 1) % 65536;
    if (arm[i] != 0) begin
      nw[i] = tnow - lt[i];
      if (nw[i] < mn[i]) mn[i] = nw[i];
      if (nw[i] > mx[i]) mx[i] = nw[i];
    end
    arm[i] = 1;
    lt[i] = tnow;
  endtask : op
  function automatic logic [15:0] exp16(input int a);
    int i;
    i = a / 4;
    case (a % 4)
      0: return cnt[i][15:0];
      1: return nw[i][15:0];
      2: return mn[i][15:0];
      default: return mx[i][15:0];
    endcase
  endfunction : exp16
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    srst = 1'b1; s_axi_awvalid = 1'b0;
    s_axi_awaddr = 12'h0; s_axi_wdata = 32'h0; s_axi_wvalid = 1'b0;
    s_axi_wstrb = 4'hf; s_axi_bready = 1'b0; s_axi_araddr = 12'h0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    for (int i = 0; i < 4; i++) mn[i] = 65535;
    void'($urandom(32'hb0a73f6b));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a <= 80; a += 4)
      axi_rd(a, a >= 64 && a < 80 ? (cyc - 10) / TICKS :
             (a % 16 == 8 && a < 64) ? 32'hffff : 32'h0, 2'b00);
    axi_rd(12'h054, 32'h0, 2'b10);
    axi_wr(12'h054, $urandom, 2'b10);
    axi_wr(12'h008, $urandom, 2'b00);
    tgt = cyc;
    for (int n = 0; n < 24; n++) begin
      if (n == 12) begin
        axi_wr(12'h050, $urandom | 1, 2'b00);
        sel = 1;
        axi_rd(12'h050, 32'h1, 2'b00);
      end
      op($urandom_range(1, 0), $urandom_range(1, 0), $urandom_range(5, 2));
    end
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 16; a++)
      axi_rd(a * 4, {16'h0, exp16(a)}, 2'b00);
    end_of_test();
  end
endmodule : tb
